// *** rtl/tpg_pkg.sv ***
// Shared constants and types for the timer and pulse generator.
// Assumes one clock at 250 MHz and a 32-bit Avalon-MM register slave.
package tpg_pkg;
    // Register byte offsets on the slave port
    localparam logic [3:0] MODE_OFS = 4'h0;
    localparam logic [3:0] MODULO_HIGH_OFS = 4'h4;
    localparam logic [3:0] MODULO_LOW_OFS = 4'h8;
    localparam logic [3:0] STAT_OFS = 4'hc;
    // Mode register fields
    localparam int OP_MODE_BIT = 0;
    localparam int RUN_BIT = 1;
    localparam int RELOAD_BIT = 3;
    localparam int STATIC_BIT = 4;
    localparam int PULSE_SEL_BIT = 5;
    localparam int PIN_DRIVE_BIT = 7;
    localparam logic [7:0] MODE_WMASK = 8'hbb;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] MODULO_HIGH_RESET = 8'h01;
    localparam logic [7:0] MODULO_LOW_RESET = 8'h04;
    localparam logic [7:0] MODULO_LOW_RMASK = 8'hfc;
    localparam int IRQ_BIT = 0;
    // One-hot prescaler selects and half divisors, minus one
    localparam logic [4:0] PRE_256 = 5'h01;
    localparam logic [4:0] PRE_128 = 5'h02;
    localparam logic [4:0] PRE_64 = 5'h04;
    localparam logic [4:0] PRE_32 = 5'h08;
    localparam logic [4:0] PRE_16 = 5'h10;
    localparam logic [7:0] HALF_256_M1 = 8'h7f;
    localparam logic [7:0] HALF_128_M1 = 8'h3f;
    localparam logic [7:0] HALF_64_M1 = 8'h1f;
    localparam logic [7:0] HALF_32_M1 = 8'h0f;
    localparam logic [7:0] HALF_16_M1 = 8'h07;
    // PWM periods in main clock cycles: basic 2^10, secondary 2^15
    localparam int BASIC_BITS = 10;
    localparam int SEC_BITS = 15;
    localparam int SUB_BITS = SEC_BITS - BASIC_BITS;
    localparam int LATCH_BITS = 14;
    localparam logic [SEC_BITS-1:0] SEC_LAST = 15'h7fff;
    localparam logic [BASIC_BITS-1:0] BASIC_LAST = 10'h3ff;
    // Pin drive: level plus active-low output enable
    typedef struct packed {
        logic level;
        logic oeN;
    } tpg_pin_t;
endpackage

// *** rtl/tpg_timer_pulse_gen.sv ***
// Timer and 14-bit PWM pulse generator with one output pin, Avalon-MM slave.
// Assumes a single 250 MHz clock; the pin's far side is a filter or load.
// Notes on behaviour
// - Mode bit 1 timer, 0 PWM
// - Timer: low modulo prescaler, high modulo count
// - Timer counts once run enable written 1
// - Square wave needs pulse select and drive
// - Stopping timer sets flip-flop, may flag
// - One-hot prescaler divides 256 down to 16
// - Square wave frequency is clock/(div*(N+1))
// - PWM sets flag every 2^15 clocks
// - PWM pulses active low, 14-bit width
// - Basic 2^10 and secondary 2^15 periods
// - Latch is high modulo plus low[7:2]
// - Latch loads whole, only when reload enabled
// - Low modulo bits 1:0 read as zero
// - PWM takes latch once per basic period
// - Static mode drives static level bit
// - Drive enable low floats pin
// - Reset clears mode register entirely
// - Run enable low stops operation
module tpg_timer_pulse_gen (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output tpg_pkg::tpg_pin_t pulseOutputPin,
    output logic pulseGenIrqFlag
);
    logic ackQ;
    logic [31:0] rdataQ;
    logic [7:0] modeQ, modeD, modHQ, modLQ;
    logic irqQ, irqD;
    logic [tpg_pkg::LATCH_BITS-1:0] latchQ, latchD, widthQ;
    logic [7:0] preQ, tmrQ;
    logic tffQ, tffD;
    logic [tpg_pkg::SEC_BITS-1:0] pwmCntQ;
    logic pinLevelQ, pinLevelD;

    // Bus decode; every access is held one cycle, answered on the second
    wire busReq = read | write;
    wire wrFire = write & ackQ;
    wire selMode = address == tpg_pkg::MODE_OFS;
    wire selModH = address == tpg_pkg::MODULO_HIGH_OFS;
    wire selModL = address == tpg_pkg::MODULO_LOW_OFS;
    wire selStat = address == tpg_pkg::STAT_OFS;
    wire [7:0] wByte = writedata[7:0];
    wire [7:0] rdByte = selMode ? modeQ :
                        selModH ? modHQ :
                        selModL ? (modLQ & tpg_pkg::MODULO_LOW_RMASK) :
                        selStat ? {7'h00, irqQ} : 8'h00;
    assign waitrequest = busReq & ~ackQ;
    assign readdata = rdataQ;

    // Mode fields
    wire timerMode = modeQ[tpg_pkg::OP_MODE_BIT];
    wire runEn = modeQ[tpg_pkg::RUN_BIT];
    wire reloadEn = modeQ[tpg_pkg::RELOAD_BIT];
    wire staticLvl = modeQ[tpg_pkg::STATIC_BIT];
    wire pulseSel = modeQ[tpg_pkg::PULSE_SEL_BIT];
    wire pinDrive = modeQ[tpg_pkg::PIN_DRIVE_BIT];

    // Register writes; reserved mode bits stay zero
    assign modeD = (wrFire & selMode) ? (wByte & tpg_pkg::MODE_WMASK) : modeQ;

    // Latch fields: high part from high modulo, low six from low[7:2]
    wire [7:0] nVal = latchQ[tpg_pkg::LATCH_BITS-1:6];
    wire [4:0] preSel = latchQ[4:0];
    assign latchD = {modHQ, modLQ[7:2]};
    wire basicEnd = pwmCntQ[tpg_pkg::BASIC_BITS-1:0] == tpg_pkg::BASIC_LAST;
    // Timer or stopped PWM reloads at any time; running PWM only at a basic period boundary
    wire latchLoad = reloadEn & (timerMode | ~runEn | basicEnd);

    // Prescaler half divisor; an illegal pattern falls back to the slowest
    wire [7:0] halfM1 = (preSel == tpg_pkg::PRE_128) ? tpg_pkg::HALF_128_M1 :
                        (preSel == tpg_pkg::PRE_64) ? tpg_pkg::HALF_64_M1 :
                        (preSel == tpg_pkg::PRE_32) ? tpg_pkg::HALF_32_M1 :
                        (preSel == tpg_pkg::PRE_16) ? tpg_pkg::HALF_16_M1 :
                        tpg_pkg::HALF_256_M1;
    wire timerRun = timerMode & runEn;
    wire halfTick = timerRun & (preQ == halfM1);
    // Two toggles per interval make the square wave period div*(N+1)
    wire tmrMatch = halfTick & (tmrQ == nVal);
    assign tffD = (timerMode & ~runEn) ? 1'b1 :
                  tmrMatch ? ~tffQ : tffQ;
    wire tffRise = timerMode & tffD & ~tffQ;

    // PWM: coarse width per basic period, fine bits spread by bit reversal
    wire [tpg_pkg::SUB_BITS-1:0] subIdx = pwmCntQ[tpg_pkg::SEC_BITS-1:tpg_pkg::BASIC_BITS];
    logic [tpg_pkg::SUB_BITS-1:0] subRev;
    genvar gi;
    generate
        for (gi = 0; gi < tpg_pkg::SUB_BITS; gi++) begin : g_rev
            assign subRev[gi] = subIdx[tpg_pkg::SUB_BITS-1-gi];
        end
    endgenerate
    wire fineAdd = subRev < widthQ[tpg_pkg::SUB_BITS-1:0];
    // Coarse part is two clocks per step; the fine bit adds one more step
    wire [tpg_pkg::BASIC_BITS:0] coarseLen =
        {1'b0, widthQ[tpg_pkg::LATCH_BITS-1:tpg_pkg::SUB_BITS], 1'b0};
    wire [tpg_pkg::BASIC_BITS:0] fineLen =
        {{(tpg_pkg::BASIC_BITS-1){1'b0}}, fineAdd, 1'b0};
    wire [tpg_pkg::BASIC_BITS:0] lowLen = coarseLen + fineLen;
    wire pwmRun = ~timerMode & runEn;
    wire pwmLow = pwmRun &
        ({1'b0, pwmCntQ[tpg_pkg::BASIC_BITS-1:0]} < lowLen);
    wire secEnd = pwmRun & (pwmCntQ == tpg_pkg::SEC_LAST);

    // Flag: a hardware set wins over a same-cycle clear
    wire irqClr = wrFire & selStat & wByte[tpg_pkg::IRQ_BIT];
    assign irqD = (tffRise | secEnd) | (irqQ & ~irqClr);

    // Pin level; PWM idles high when stopped
    assign pinLevelD = ~pulseSel ? staticLvl :
                       timerMode ? tffQ : ~pwmLow;
    assign pulseOutputPin.level = pinLevelQ;
    assign pulseOutputPin.oeN = ~pinDrive;
    assign pulseGenIrqFlag = irqQ;

    // Bus handshake and read data
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ackQ <= 1'b0;
            rdataQ <= 32'h0000_0000;
        end else begin
            ackQ <= busReq & ~ackQ;
            rdataQ <= (read & ~ackQ) ? {24'h00_0000, rdByte} : rdataQ;
        end
    end

    // Software-visible registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            modeQ <= tpg_pkg::MODE_RESET;
            modHQ <= tpg_pkg::MODULO_HIGH_RESET;
            modLQ <= tpg_pkg::MODULO_LOW_RESET;
            irqQ <= 1'b0;
        end else begin
            modeQ <= modeD;
            modHQ <= (wrFire & selModH) ? wByte : modHQ;
            modLQ <= (wrFire & selModL) ? wByte : modLQ;
            irqQ <= irqD;
        end
    end

    // Modulo latch and the PWM copy taken per basic period
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            latchQ <= {tpg_pkg::MODULO_HIGH_RESET, tpg_pkg::MODULO_LOW_RESET[7:2]};
            widthQ <= {tpg_pkg::MODULO_HIGH_RESET, tpg_pkg::MODULO_LOW_RESET[7:2]};
        end else begin
            latchQ <= latchLoad ? latchD : latchQ;
            widthQ <= (basicEnd | ~pwmRun) ? latchQ : widthQ;
        end
    end

    // Timer prescaler, interval counter and toggle flip-flop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            preQ <= 8'h00;
            tmrQ <= 8'h00;
            tffQ <= 1'b0;
        end else begin
            preQ <= (~timerRun | halfTick) ? 8'h00 : preQ + 8'h01;
            tmrQ <= (~timerRun | tmrMatch) ? 8'h00 : (halfTick ? tmrQ + 8'h01 : tmrQ);
            tffQ <= tffD;
        end
    end

    // PWM secondary-period counter; stopping clears it to save power
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pwmCntQ <= '0;
            pinLevelQ <= 1'b0;
        end else begin
            pwmCntQ <= pwmRun ? pwmCntQ + 15'h0001 : 15'h0000;
            pinLevelQ <= pinLevelD;
        end
    end

    // Checks on the behaviour above
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_modeWrite;
        wrFire && selMode;
    endsequence

    property p_modeWrite;
        s_modeWrite |=> modeQ == ($past(wByte) & tpg_pkg::MODE_WMASK);
    endproperty
    a_modeWrite: assert property (p_modeWrite) else $error("mode write lost");

    property p_floatPin;
        s_modeWrite ##0 !wByte[tpg_pkg::PIN_DRIVE_BIT] |=> pulseOutputPin.oeN;
    endproperty
    a_floatPin: assert property (p_floatPin) else $error("pin not floated");

    property p_pwmFlag;
        secEnd |=> irqQ && pwmCntQ == 15'h0000;
    endproperty
    a_pwmFlag: assert property (p_pwmFlag) else $error("PWM flag missing");

    property p_flagHold;
        irqQ && !irqClr |=> irqQ;
    endproperty
    a_flagHold: assert property (p_flagHold) else $error("flag dropped");

    property p_noReload;
        !reloadEn |=> $stable(latchQ);
    endproperty
    a_noReload: assert property (p_noReload) else $error("latch moved");

    property p_widthStep;
        pwmRun && !$past(basicEnd) && $past(pwmRun) |-> $stable(widthQ);
    endproperty
    a_widthStep: assert property (p_widthStep) else $error("width changed mid period");

    property p_staticPin;
        !pulseSel && $stable(modeQ) |=> pinLevelQ == $past(staticLvl);
    endproperty
    a_staticPin: assert property (p_staticPin) else $error("static level wrong");

    property p_stopSetsTff;
        timerMode && $fell(runEn) |=> tffQ ##1 tffQ;
    endproperty
    a_stopSetsTff: assert property (p_stopSetsTff) else $error("stop left flip-flop low");

    property p_stopped;
        !runEn |=> pwmCntQ == 15'h0000 && preQ == 8'h00;
    endproperty
    a_stopped: assert property (p_stopped) else $error("counters run while stopped");

    property p_squareFollow;
        timerMode && pulseSel |=> pinLevelQ == $past(tffQ);
    endproperty
    a_squareFollow: assert property (p_squareFollow) else $error("square wave wrong");

    // Timer start, prescaler step, toggle and stop
    sequence s_pre16Start;
        timerRun && preSel == tpg_pkg::PRE_16 && preQ == 8'h00;
    endsequence

    sequence s_pre16Hold;
        (timerRun && preSel == tpg_pkg::PRE_16) [*7];
    endsequence

    property p_runStart;
        timerMode && $rose(runEn) |=> preQ == 8'h01;
    endproperty
    a_runStart: assert property (p_runStart) else $error("timer did not start");

    property p_pre16;
        s_pre16Start ##1 s_pre16Hold |-> halfTick && preQ == tpg_pkg::HALF_16_M1;
    endproperty
    a_pre16: assert property (p_pre16) else $error("prescaler step wrong");

    property p_tffToggle;
        tmrMatch |=> tffQ != $past(tffQ);
    endproperty
    a_tffToggle: assert property (p_tffToggle) else $error("flip-flop did not toggle");

    property p_timerIdle;
        timerMode && !runEn |=> tmrQ == 8'h00 && tffQ;
    endproperty
    a_timerIdle: assert property (p_timerIdle) else $error("stopped timer still counts");

    property p_squareDrive;
        timerMode && pulseSel && pinDrive |-> !pulseOutputPin.oeN;
    endproperty
    a_squareDrive: assert property (p_squareDrive) else $error("square wave not driven");

    property p_latchCopy;
        reloadEn && timerMode |=> latchQ == {$past(modHQ), $past(modLQ[7:2])};
    endproperty
    a_latchCopy: assert property (p_latchCopy) else $error("latch fields wrong");

    // Flag sets, clears and stays quiet between events
    property p_flagFromTff;
        tffRise |=> irqQ;
    endproperty
    a_flagFromTff: assert property (p_flagFromTff) else $error("flip-flop rise lost");

    property p_clearWorks;
        irqClr && !tffRise && !secEnd |=> !irqQ;
    endproperty
    a_clearWorks: assert property (p_clearWorks) else $error("flag clear ignored");

    property p_noSpurious;
        !irqQ && !tffRise && !secEnd |=> !irqQ;
    endproperty
    a_noSpurious: assert property (p_noSpurious) else $error("flag set without event");

    // PWM pin: low at each period start, high at its end, high when idle
    property p_pulseLow;
        pwmRun && pulseSel && pwmCntQ[tpg_pkg::BASIC_BITS-1:0] == '0 &&
            widthQ[tpg_pkg::LATCH_BITS-1:tpg_pkg::SUB_BITS] != '0 |=> !pinLevelQ;
    endproperty
    a_pulseLow: assert property (p_pulseLow) else $error("pulse did not go low");

    property p_pulseHigh;
        pwmRun && pulseSel && basicEnd &&
            !(&widthQ[tpg_pkg::LATCH_BITS-1:tpg_pkg::SUB_BITS]) |=> pinLevelQ;
    endproperty
    a_pulseHigh: assert property (p_pulseHigh) else $error("pulse high part missing");

    property p_pwmIdle;
        !timerMode && !runEn && pulseSel |=> pinLevelQ;
    endproperty
    a_pwmIdle: assert property (p_pwmIdle) else $error("idle PWM pin not high");
endmodule

// *** tb/tpg_load_model.sv ***
// Load on the pulse pin: a filter input with a weak pull-up.
// Assumes the pin struct from tpg_pkg and the bench clock.
module tpg_load_model (
    input wire logic clk,
    input wire tpg_pkg::tpg_pin_t pin,
    input wire logic countEn,
    output logic lineLevel,
    output int lowCount
);
    // Released pin floats up, so high-Z never reads as a stale level
    assign lineLevel = pin.oeN ? 1'b1 : pin.level;
    // Low-time integrator, stands in for the filter's averaging
    always @(posedge clk) begin
        if (!countEn) lowCount <= 0;
        else if (lineLevel === 1'b0) lowCount <= lowCount + 1;
    end
endmodule

// *** tb/tpg_timer_pulse_gen_test.sv ***
// Self-checking bench for the timer and PWM pulse generator.
// Assumes an Avalon slave with waitrequest and a 250 MHz clock.
module tpg_timer_pulse_gen_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, nrst = 0, read = 0, write = 0, countEn = 0, lineLevel;
    logic [3:0] address = 0;
    logic [31:0] writedata = 0, readdata, rd;
    logic waitrequest, pulseGenIrqFlag;
    tpg_pkg::tpg_pin_t pulseOutputPin;
    int lowCount, bad_count = 0, checks = 0, cyc, k, latch;
    logic [7:0] n, m;
    always #2 clk = ~clk;
    tpg_timer_pulse_gen u_dut (.clk(clk), .nrst(nrst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .pulseOutputPin(pulseOutputPin),
        .pulseGenIrqFlag(pulseGenIrqFlag));
    tpg_load_model u_load (.clk(clk), .pin(pulseOutputPin), .countEn(countEn),
        .lineLevel(lineLevel), .lowCount(lowCount));
    task end_sim;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Expected square period and PWM low time, two clocks per latch step
    function automatic int exp_period(input int sel, input logic [7:0] cnt);
        return (256 >> sel) * (cnt + 1);
    endfunction
    function automatic int exp_low(input int value);
        return 2 * value;
    endfunction
    // One Avalon access; request held until waitrequest seen low
    task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= {24'h0, d};
        // Only the watchdog ends a wait that never sees an answer
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        rd = readdata;
        read <= 0;
        write <= 0;
    endtask
    // Counts clocks up to the next low-to-high edge on the line
    task to_rise;
        repeat (3000) begin
            @(negedge clk);
            cyc++;
            if (lineLevel === 1'b0) break;
        end
        repeat (3000) begin
            @(negedge clk);
            cyc++;
            if (lineLevel === 1'b1) break;
        end
    endtask
    // Low clocks in one secondary period for a latch value
    task pwm_low(input int exp);
        bus(1, tpg_pkg::STAT_OFS, 8'h01);
        repeat (2100) @(posedge clk);
        countEn <= 1;
        repeat (32768) @(posedge clk);
        countEn <= 0;
        @(negedge clk);
        chk(lowCount, exp);
        chk(pulseGenIrqFlag, 1);
    endtask
    initial begin
        void'($urandom(32'hbabf1e86));
        repeat (6) @(posedge clk);
        nrst <= 1;
        @(negedge clk);
        chk(pulseOutputPin.oeN, 1);
        bus(0, tpg_pkg::MODE_OFS, 0);
        chk(rd, 0);
        bus(0, tpg_pkg::MODULO_LOW_OFS, 0);
        chk(rd & 32'hfc, tpg_pkg::MODULO_LOW_RESET);
        bus(0, 4'h2, 0);
        chk(rd, 0);
        $display("reset and map test done");
        for (k = 0; k < 2; k++) begin
            bus(1, tpg_pkg::MODE_OFS, 8'h80 | (k << 4));
            repeat (2) @(posedge clk);
            chk(lineLevel, k);
        end
        $display("static test done");
        for (k = 0; k < 5; k++) begin
            n = 8'(1 + $urandom % 3);
            bus(1, tpg_pkg::MODULO_HIGH_OFS, n);
            bus(1, tpg_pkg::MODULO_LOW_OFS, 8'(4 << k));
            bus(1, tpg_pkg::MODE_OFS, 8'hab);
            to_rise;
            cyc = 0;
            to_rise;
            chk(cyc, exp_period(k, n));
            chk(pulseGenIrqFlag, 1);
            bus(1, tpg_pkg::STAT_OFS, 8'h01);
            bus(0, tpg_pkg::STAT_OFS, 0);
            chk(rd[0], 0);
            bus(1, tpg_pkg::MODE_OFS, 8'ha9);
        end
        bus(1, tpg_pkg::STAT_OFS, 8'h01);
        repeat (1200) @(posedge clk);
        chk(pulseGenIrqFlag, 0);
        $display("timer test done");
        n = 8'(1 + $urandom % 254);
        m = 8'($urandom) & 8'hfc;
        latch = {n, m[7:2]};
        bus(1, tpg_pkg::MODULO_HIGH_OFS, n);
        bus(1, tpg_pkg::MODULO_LOW_OFS, m);
        bus(1, tpg_pkg::MODE_OFS, 8'ha8);
        bus(1, tpg_pkg::MODE_OFS, 8'haa);
        pwm_low(exp_low(latch));
        bus(1, tpg_pkg::MODE_OFS, 8'ha2);
        bus(1, tpg_pkg::MODULO_HIGH_OFS, ~n);
        pwm_low(exp_low(latch));
        $display("pwm test done");
        end_sim;
    end
    // Hang guard sized above the roughly 75k-cycle run
    initial begin
        #400000;
        bad_count++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim;
    end
endmodule
